/* hw/sram_port_params.svh */
// Register indices, field positions, reset values and decode constants of the SRAM port bank.
`ifndef SRAM_PORT_PARAMS_SVH
`define SRAM_PORT_PARAMS_SVH

// Register indices; the AXI byte address is four times the index.
`define IDX_VENDOR_LO 8'h28
`define IDX_VENDOR_HI 8'h29
`define IDX_PRODUCT_LO 8'h2A
`define IDX_PRODUCT_HI 8'h2B
`define IDX_REVISION 8'h2C
`define IDX_TEST_MODE 8'h2F
`define IDX_RX_PEEK 8'hF0
`define IDX_RX_STREAM 8'hF2
`define IDX_RX_PTR_LO 8'hF4
`define IDX_RX_PTR_HI 8'hF5
`define IDX_TX_HOLD 8'hF6
`define IDX_TX_STREAM 8'hF8
`define IDX_TX_PTR_LO 8'hFA
`define IDX_TX_PTR_HI 8'hFB
`define IDX_TX_LEN_LO 8'hFC
`define IDX_TX_LEN_HI 8'hFD
`define IDX_EVENT_STATUS 8'hFE
`define IDX_EVENT_MASK 8'hFF

// Field positions.
`define BIT_TEST_ENABLE 7
`define BIT_LATE_COLL 2
`define BIT_LONG_BACKOFF 1
`define BIT_SHORT_BACKOFF 0
`define BIT_WRAP_ENABLE 7
`define BIT_WIDTH_HI 7
`define BIT_WIDTH_LO 6

// Reset and load values.
`define RST_BYTE 8'h00
`define RST_PTR 16'h0000
`define RST_EVENTS 4'h0
`define WRAP_RX_HIGH 8'h0C

// Host bus width codes.
`define WIDTH_16 2'h0
`define WIDTH_32 2'h1
`define WIDTH_8 2'h2

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* hw/sram_port_pkg.sv */
// Types shared by the SRAM port register bank.
package sram_port_pkg;

  // Four event latches, highest bit first.
  typedef struct packed {
    logic ctr_wrap;
    logic rx_ovf;
    logic pkt_sent;
    logic pkt_arrived;
  } event_t;

  typedef struct packed {
    logic test_mode_enable;
    logic force_late_collision;
    logic force_longest_backoff;
    logic force_shortest_backoff;
  } test_mode_t;

  typedef struct packed {
    logic en;
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } tx_sram_wr_t;

endpackage

/* hw/sram_port_regs.sv */
// AXI4-Lite register bank with RX/TX packet SRAM data ports of an Ethernet controller.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_params.svh"

// Functional notes
// - Read-only vendor code, low byte at 28H, high byte at 29H.
// - Read-only product code, low byte at 2AH, high byte at 2BH.
// - Read-only silicon revision byte at 2CH.
// - Test mode register 2FH: enable bit 7, late collision bit 2, bits 6:3 zero.
// - Bit 1 forces longest back-off, bit 0 shortest; both read-write, reset zero.
// - Reading F0H returns RX SRAM data, pointer unchanged.
// - Reading F2H returns RX SRAM data, then pointer advances 1, 2 or 4.
// - RX pointer at F4H/F5H, reset zero; high byte loads 0Ch on wrap enable.
// - Writing F6H stores into TX SRAM, pointer unchanged.
// - Writing F8H stores into TX SRAM, then pointer advances 1, 2 or 4.
// - TX pointer read-write at FAH/FBH, reset zero.
// - TX packet length read-write at FCH/FDH.
// - Status bits 7:6 report host bus width, read-only.
// - Status FEH latches four events; reset zero, write one clears.
// - With wrap enable, pointers return to start when passing SRAM size.
// - Mask bits 3 to 0 enable each latch toward the interrupt output.
module sram_port_regs #(
  parameter int ADDR_W = 10,
  parameter logic [15:0] VENDOR_CODE = 16'h1234,
  parameter logic [15:0] PRODUCT_CODE = 16'h5678,
  parameter logic [7:0] REVISION_CODE = 8'h01,
  parameter logic [15:0] RX_START = 16'h0C00,
  parameter logic [15:0] RX_TOP = 16'h3FFF,
  parameter logic [15:0] TX_START = 16'h0000,
  parameter logic [15:0] TX_TOP = 16'h0BFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] host_bus_width,
  input wire sram_port_pkg::event_t event_pulse,
  output logic [15:0] rx_rd_addr,
  input wire logic [31:0] rx_rd_data,
  output sram_port_pkg::tx_sram_wr_t tx_wr,
  output sram_port_pkg::test_mode_t test_mode,
  output logic [15:0] tx_length,
  output logic irq
);
  import sram_port_pkg::*;

  // ****************************************
  // Bus width strap and pointer step
  // ****************************************
  // The strap is caught once, in the first cycle after reset is released.
  logic [1:0] width_q;
  logic width_done_q;
  logic [15:0] step;
  logic [31:0] lane_mask;
  logic [3:0] strb_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      width_q <= `WIDTH_16;
      width_done_q <= 1'b0;
    end else if (!width_done_q) begin
      width_q <= host_bus_width;
      width_done_q <= 1'b1;
    end
  end

  // Reserved width code is handled as 8-bit so no lane is ever skipped.
  always_comb begin
    if (width_q == `WIDTH_32) begin
      step = 16'h0004;
      lane_mask = 32'hFFFFFFFF;
      strb_mask = 4'hF;
    end else if (width_q == `WIDTH_16) begin
      step = 16'h0002;
      lane_mask = 32'h0000FFFF;
      strb_mask = 4'h3;
    end else begin
      step = 16'h0001;
      lane_mask = 32'h000000FF;
      strb_mask = 4'h1;
    end
  end

  // ****************************************
  // Pointer advance with optional wrap
  // ****************************************
  function automatic logic [15:0] advance(input logic [15:0] ptr, input logic [15:0] inc,
                                          input logic wrap, input logic [15:0] start,
                                          input logic [15:0] top);
    logic [16:0] nxt;
    nxt = {1'b0, ptr} + {1'b0, inc};
    if (wrap && nxt > {1'b0, top}) begin
      nxt = nxt - {1'b0, top} - 17'h00001 + {1'b0, start};
    end
    return nxt[15:0];
  endfunction

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] wr_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_wr;
  logic wr_hit;
  logic wr_lo;

  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready = !w_got_q;
  assign do_wr = aw_got_q && w_got_q && !bvalid_q;
  assign wr_lo = do_wr && wstrb_q[0];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wr_idx_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q <= 1'b1;
        wr_idx_q <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = (wr_idx_q == `IDX_TEST_MODE) || (wr_idx_q == `IDX_RX_PTR_LO) ||
             (wr_idx_q == `IDX_RX_PTR_HI) || (wr_idx_q == `IDX_TX_HOLD) ||
             (wr_idx_q == `IDX_TX_STREAM) || (wr_idx_q == `IDX_TX_PTR_LO) ||
             (wr_idx_q == `IDX_TX_PTR_HI) || (wr_idx_q == `IDX_TX_LEN_LO) ||
             (wr_idx_q == `IDX_TX_LEN_HI) || (wr_idx_q == `IDX_EVENT_STATUS) ||
             (wr_idx_q == `IDX_EVENT_MASK);
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rd_take;
  logic [7:0] rd_idx;
  logic [31:0] rd_val;
  logic rd_hit;

  assign s_axi_arready = !rvalid_q;
  assign rd_take = s_axi_arvalid && !rvalid_q;
  assign rd_idx = s_axi_araddr[9:2];
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Control and status registers
  // ****************************************
  test_mode_t test_q;
  logic [15:0] rx_ptr_q;
  logic [15:0] tx_ptr_q;
  logic [15:0] tx_len_q;
  event_t events_q;
  logic [3:0] mask_q;
  logic wrap_en_q;
  tx_sram_wr_t tx_wr_q;

  assign test_mode = test_q;
  assign rx_rd_addr = rx_ptr_q;
  assign tx_wr = tx_wr_q;
  assign tx_length = tx_len_q;

  // Reserved bits 6:3 are not stored, so they always read zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_q <= '0;
    end else if (wr_lo && wr_idx_q == `IDX_TEST_MODE) begin
      test_q.test_mode_enable <= wdata_q[`BIT_TEST_ENABLE];
      test_q.force_late_collision <= wdata_q[`BIT_LATE_COLL];
      test_q.force_longest_backoff <= wdata_q[`BIT_LONG_BACKOFF];
      test_q.force_shortest_backoff <= wdata_q[`BIT_SHORT_BACKOFF];
    end
  end

  // A pointer write by software beats an increment in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ptr_q <= `RST_PTR;
    end else if (wr_lo && wr_idx_q == `IDX_EVENT_MASK && wdata_q[`BIT_WRAP_ENABLE]) begin
      rx_ptr_q[15:8] <= `WRAP_RX_HIGH;
    end else if (wr_lo && wr_idx_q == `IDX_RX_PTR_LO) begin
      rx_ptr_q[7:0] <= wdata_q[7:0];
    end else if (wr_lo && wr_idx_q == `IDX_RX_PTR_HI) begin
      rx_ptr_q[15:8] <= wdata_q[7:0];
    end else if (rd_take && rd_idx == `IDX_RX_STREAM) begin
      rx_ptr_q <= advance(rx_ptr_q, step, wrap_en_q, RX_START, RX_TOP);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ptr_q <= `RST_PTR;
    end else if (wr_lo && wr_idx_q == `IDX_TX_PTR_LO) begin
      tx_ptr_q[7:0] <= wdata_q[7:0];
    end else if (wr_lo && wr_idx_q == `IDX_TX_PTR_HI) begin
      tx_ptr_q[15:8] <= wdata_q[7:0];
    end else if (do_wr && wr_idx_q == `IDX_TX_STREAM) begin
      tx_ptr_q <= advance(tx_ptr_q, step, wrap_en_q, TX_START, TX_TOP);
    end
  end

  // The store uses the pointer before any advance of the same access.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_wr_q <= '0;
    end else begin
      tx_wr_q.en <= do_wr && (wr_idx_q == `IDX_TX_HOLD || wr_idx_q == `IDX_TX_STREAM);
      if (do_wr && (wr_idx_q == `IDX_TX_HOLD || wr_idx_q == `IDX_TX_STREAM)) begin
        tx_wr_q.addr <= tx_ptr_q;
        tx_wr_q.data <= wdata_q & lane_mask;
        tx_wr_q.strb <= wstrb_q & strb_mask;
      end
    end
  end

  // Length has no documented reset value; it is cleared to keep simulation defined.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_len_q <= 16'h0000;
    end else if (wr_lo && wr_idx_q == `IDX_TX_LEN_LO) begin
      tx_len_q[7:0] <= wdata_q[7:0];
    end else if (wr_lo && wr_idx_q == `IDX_TX_LEN_HI) begin
      tx_len_q[15:8] <= wdata_q[7:0];
    end
  end

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      events_q <= `RST_EVENTS;
    end else if (wr_lo && wr_idx_q == `IDX_EVENT_STATUS) begin
      events_q <= (events_q & ~wdata_q[3:0]) | event_pulse;
    end else begin
      events_q <= events_q | event_pulse;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= 4'h0;
      wrap_en_q <= 1'b0;
    end else if (wr_lo && wr_idx_q == `IDX_EVENT_MASK) begin
      mask_q <= wdata_q[3:0];
      wrap_en_q <= wdata_q[`BIT_WRAP_ENABLE];
    end
  end

  assign irq = |(events_q & mask_q);

  // ****************************************
  // Read decode
  // ****************************************
  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (rd_idx == `IDX_VENDOR_LO) begin
      rd_val[7:0] = VENDOR_CODE[7:0];
    end else if (rd_idx == `IDX_VENDOR_HI) begin
      rd_val[7:0] = VENDOR_CODE[15:8];
    end else if (rd_idx == `IDX_PRODUCT_LO) begin
      rd_val[7:0] = PRODUCT_CODE[7:0];
    end else if (rd_idx == `IDX_PRODUCT_HI) begin
      rd_val[7:0] = PRODUCT_CODE[15:8];
    end else if (rd_idx == `IDX_REVISION) begin
      rd_val[7:0] = REVISION_CODE;
    end else if (rd_idx == `IDX_TEST_MODE) begin
      rd_val[7:0] = {test_q.test_mode_enable, 4'h0, test_q.force_late_collision,
                     test_q.force_longest_backoff, test_q.force_shortest_backoff};
    end else if (rd_idx == `IDX_RX_PEEK || rd_idx == `IDX_RX_STREAM) begin
      rd_val = rx_rd_data & lane_mask;
    end else if (rd_idx == `IDX_RX_PTR_LO) begin
      rd_val[7:0] = rx_ptr_q[7:0];
    end else if (rd_idx == `IDX_RX_PTR_HI) begin
      rd_val[7:0] = rx_ptr_q[15:8];
    end else if (rd_idx == `IDX_TX_HOLD || rd_idx == `IDX_TX_STREAM) begin
      rd_val = 32'h00000000;
    end else if (rd_idx == `IDX_TX_PTR_LO) begin
      rd_val[7:0] = tx_ptr_q[7:0];
    end else if (rd_idx == `IDX_TX_PTR_HI) begin
      rd_val[7:0] = tx_ptr_q[15:8];
    end else if (rd_idx == `IDX_TX_LEN_LO) begin
      rd_val[7:0] = tx_len_q[7:0];
    end else if (rd_idx == `IDX_TX_LEN_HI) begin
      rd_val[7:0] = tx_len_q[15:8];
    end else if (rd_idx == `IDX_EVENT_STATUS) begin
      rd_val[7:0] = {width_q, 2'h0, events_q};
    end else if (rd_idx == `IDX_EVENT_MASK) begin
      rd_val[7:0] = {wrap_en_q, 3'h0, mask_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_vendor_low;
    rd_take && rd_idx == `IDX_VENDOR_LO |=> s_axi_rvalid && s_axi_rdata == {24'h0, VENDOR_CODE[7:0]};
  endproperty
  a_vendor_low: assert property (p_vendor_low) else $error("Vendor low byte wrong.");

  property p_product_high;
    rd_take && rd_idx == `IDX_PRODUCT_HI |=> s_axi_rdata[7:0] == PRODUCT_CODE[15:8];
  endproperty
  a_product_high: assert property (p_product_high) else $error("Product high byte wrong.");

  property p_peek_keeps;
    rd_take && rd_idx == `IDX_RX_PEEK && !do_wr |=> $stable(rx_ptr_q);
  endproperty
  a_peek_keeps: assert property (p_peek_keeps) else $error("Peek read moved pointer.");

  property p_stream_step;
    rd_take && rd_idx == `IDX_RX_STREAM && !do_wr && !wrap_en_q
      |=> rx_ptr_q == $past(rx_ptr_q) + $past(step);
  endproperty
  a_stream_step: assert property (p_stream_step) else $error("RX stream step wrong.");

  property p_wrap_high;
    wr_lo && wr_idx_q == `IDX_EVENT_MASK && wdata_q[`BIT_WRAP_ENABLE] |=> rx_ptr_q[15:8] == 8'h0C;
  endproperty
  a_wrap_high: assert property (p_wrap_high) else $error("Wrap enable did not load 0Ch.");

  property p_hold_store;
    do_wr && wr_idx_q == `IDX_TX_HOLD
      |=> tx_wr_q.en && tx_wr_q.addr == $past(tx_ptr_q) && $stable(tx_ptr_q);
  endproperty
  a_hold_store: assert property (p_hold_store) else $error("TX hold store wrong.");

  property p_tx_stream;
    do_wr && wr_idx_q == `IDX_TX_STREAM && !wrap_en_q
      |=> tx_wr_q.en ##0 tx_ptr_q == $past(tx_ptr_q) + $past(step);
  endproperty
  a_tx_stream: assert property (p_tx_stream) else $error("TX stream step wrong.");

  property p_width_field;
    rd_take && rd_idx == `IDX_EVENT_STATUS |=> s_axi_rdata[7:6] == width_q;
  endproperty
  a_width_field: assert property (p_width_field) else $error("Width field wrong.");

  property p_event_sets;
    event_pulse.pkt_arrived |=> events_q.pkt_arrived;
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("Event latch lost.");

  property p_irq_masked;
    mask_q == 4'h0 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("Masked interrupt raised.");

endmodule // sram_port_regs
`default_nettype wire

/* test/ethernet_ctrl_sram_port_regs_bench.sv */
// Self-checking bench of the SRAM port register bank over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_params.svh"
module ethernet_ctrl_sram_port_regs_bench;
  import sram_port_pkg::*;
  // Identity values are arbitrary.
  localparam logic [15:0] VENDOR = 16'hB1C2;
  localparam logic [15:0] PRODUCT = 16'hD3E4;
  localparam logic [7:0] REV = 8'h5F;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = 10'h0;
  logic [9:0] araddr = 10'h0;
  // Response readies stay high, so back-to-back transfers never toggle them in one time step.
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] width = 2'h0;
  event_t ev = 4'h0;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, rx_data;
  wire logic [15:0] rx_addr, tx_length;
  wire tx_sram_wr_t tx_wr;
  wire test_mode_t test_mode;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] rd_v;
  logic [1:0] rsp;

  sram_port_regs #(.VENDOR_CODE(VENDOR), .PRODUCT_CODE(PRODUCT), .REVISION_CODE(REV)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .host_bus_width(width), .event_pulse(ev), .rx_rd_addr(rx_addr), .rx_rd_data(rx_data),
    .tx_wr(tx_wr), .test_mode(test_mode), .tx_length(tx_length), .irq(irq));
  sram_model mem_u (.aclk(aclk), .rx_rd_addr(rx_addr), .rx_rd_data(rx_data), .tx_wr(tx_wr));

  always #50 aclk = ~aclk;

  // ******************************************************
  // Bus cycles and comparison
  // ******************************************************
  task summarize;
    $display("Comparisons: %0d, mismatches: %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask
  task expire(input string what);
    n_errors++;
    $display("ERROR %s expected answer seen timeout", what);
    summarize();
  endtask
  // Ready is sampled at the falling edge and the item released at the next rising edge;
  // ready depends only on slave state, so it cannot change in between.
  task wr(input logic [7:0] idx, input logic [31:0] d);
    int n;
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad | (awready === 1'b1);
      wd = wd | (wready === 1'b1);
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
      n++;
      if (n > 50) expire("write address");
    end
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 50) expire("write response");
    end while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] idx);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      n++;
      if (n > 50) expire("read address");
    end while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 100) expire("read data");
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rsp = rresp;
    @(posedge aclk);
  endtask
  task rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(what, rd_v, exp);
  endtask
  // Combinational irq is looked at away from the edge that updates the latches.
  task chk_irq(input logic exp);
    @(negedge aclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
    @(posedge aclk);
  endtask
  task do_reset(input logic [1:0] w);
    @(posedge aclk);
    aresetn <= 1'b0;
    width <= w;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  function automatic logic [31:0] rxw(input logic [15:0] a);
    return {a ^ 16'hA5A5, a};
  endfunction

  // ******************************************************
  // Scenarios
  // ******************************************************
  task t_ids;
    rchk("vendor low", `IDX_VENDOR_LO, {24'h0, VENDOR[7:0]});
    rchk("vendor high", `IDX_VENDOR_HI, {24'h0, VENDOR[15:8]});
    wr(`IDX_VENDOR_LO, 32'hFF);
    rchk("vendor low kept", `IDX_VENDOR_LO, {24'h0, VENDOR[7:0]});
    rchk("product low", `IDX_PRODUCT_LO, {24'h0, PRODUCT[7:0]});
    rchk("product high", `IDX_PRODUCT_HI, {24'h0, PRODUCT[15:8]});
    rchk("revision", `IDX_REVISION, {24'h0, REV});
    rchk("test mode reset", `IDX_TEST_MODE, 32'h0);
    rchk("rx pointer low", `IDX_RX_PTR_LO, 32'h0);
    rchk("rx pointer high", `IDX_RX_PTR_HI, 32'h0);
    rchk("tx pointer low", `IDX_TX_PTR_LO, 32'h0);
    rchk("tx pointer high", `IDX_TX_PTR_HI, 32'h0);
    rd(8'h00);
    chk("unmapped read resp", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
  endtask
  task t_mode;
    wr(`IDX_TEST_MODE, 32'hFF);
    chk("test mode write resp", {30'h0, rsp}, {30'h0, `RESP_OKAY});
    rchk("test mode", `IDX_TEST_MODE, 32'h87);
    chk("test mode pins", {28'h0, test_mode}, 32'hF);
    wr(`IDX_TEST_MODE, 32'h02);
    rchk("test mode longest", `IDX_TEST_MODE, 32'h02);
    chk("test mode pins longest", {28'h0, test_mode}, 32'h2);
  endtask
  task t_len;
    wr(`IDX_TX_LEN_LO, 32'h34);
    wr(`IDX_TX_LEN_HI, 32'h12);
    chk("tx length pins", {16'h0, tx_length}, 32'h1234);
    rchk("tx length low", `IDX_TX_LEN_LO, 32'h34);
    rchk("tx length high", `IDX_TX_LEN_HI, 32'h12);
  endtask
  task t_events;
    wr(`IDX_EVENT_MASK, 32'h01);
    ev <= 4'hF;
    @(posedge aclk);
    ev <= 4'h0;
    rchk("events set", `IDX_EVENT_STATUS, {24'h0, width, 6'h0F});
    chk_irq(1'b1);
    wr(`IDX_EVENT_STATUS, 32'h01);
    rchk("event bit 0 cleared", `IDX_EVENT_STATUS, {24'h0, width, 6'h0E});
    chk_irq(1'b0);
    wr(`IDX_EVENT_MASK, 32'h08);
    chk_irq(1'b1);
    wr(`IDX_EVENT_STATUS, 32'h0E);
    rchk("events cleared", `IDX_EVENT_STATUS, {24'h0, width, 6'h00});
    chk_irq(1'b0);
    wr(`IDX_EVENT_MASK, 32'h00);
  endtask
  task t_ports(input logic [1:0] w);
    logic [15:0] s;
    logic [15:0] p;
    logic [31:0] m;
    int c0;
    s = (w == `WIDTH_32) ? 16'h4 : (w == `WIDTH_16) ? 16'h2 : 16'h1;
    m = (w == `WIDTH_32) ? 32'hFFFFFFFF : (w == `WIDTH_16) ? 32'hFFFF : 32'hFF;
    c0 = mem_u.tx_count;
    chk("test mode pins after reset", {28'h0, test_mode}, 32'h0);
    rchk("bus width", `IDX_EVENT_STATUS, {24'h0, w, 6'h0});
    wr(`IDX_RX_PTR_LO, 32'h10);
    wr(`IDX_RX_PTR_HI, 32'h01);
    rchk("peek data", `IDX_RX_PEEK, rxw(16'h0110) & m);
    rchk("stream data 0", `IDX_RX_STREAM, rxw(16'h0110) & m);
    rchk("stream data 1", `IDX_RX_STREAM, rxw(16'h0110 + s) & m);
    p = 16'h0110 + 2 * s;
    rchk("rx pointer after stream", `IDX_RX_PTR_LO, {24'h0, p[7:0]});
    wr(`IDX_TX_PTR_LO, 32'h20);
    wr(`IDX_TX_PTR_HI, 32'h01);
    wr(`IDX_TX_HOLD, 32'hCAFEF00D);
    rchk("tx pointer after hold", `IDX_TX_PTR_LO, 32'h20);
    chk("tx hold address", {16'h0, mem_u.tx_addr}, 32'h0120);
    chk("tx hold data", mem_u.tx_data & m, 32'hCAFEF00D & m);
    wr(`IDX_TX_STREAM, 32'h11223344);
    wr(`IDX_TX_STREAM, 32'h55667788);
    p = 16'h0120 + 2 * s;
    rchk("tx pointer after stream", `IDX_TX_PTR_LO, {24'h0, p[7:0]});
    chk("tx stream address", {16'h0, mem_u.tx_addr}, {16'h0, 16'h0120 + s});
    chk("tx write count", 32'(mem_u.tx_count - c0), 32'd3);
    wr(`IDX_EVENT_MASK, 32'h80);
    rchk("rx high on wrap enable", `IDX_RX_PTR_HI, 32'h0C);
    p = 16'h4000 - s;
    wr(`IDX_RX_PTR_LO, {24'h0, p[7:0]});
    wr(`IDX_RX_PTR_HI, {24'h0, p[15:8]});
    rd(`IDX_RX_STREAM);
    rchk("rx wrap high", `IDX_RX_PTR_HI, 32'h0C);
    rchk("rx wrap low", `IDX_RX_PTR_LO, 32'h00);
    p = 16'h0C00 - s;
    wr(`IDX_TX_PTR_LO, {24'h0, p[7:0]});
    wr(`IDX_TX_PTR_HI, {24'h0, p[15:8]});
    wr(`IDX_TX_STREAM, 32'h0);
    rchk("tx wrap high", `IDX_TX_PTR_HI, 32'h00);
    rchk("tx wrap low", `IDX_TX_PTR_LO, 32'h00);
  endtask

  initial begin
    do_reset(`WIDTH_16);
    t_ids();
    t_mode();
    t_len();
    t_events();
    do_reset(`WIDTH_8);
    t_ports(`WIDTH_8);
    do_reset(`WIDTH_16);
    t_ports(`WIDTH_16);
    do_reset(`WIDTH_32);
    t_ports(`WIDTH_32);
    summarize();
  end
endmodule // ethernet_ctrl_sram_port_regs_bench
`default_nettype wire

/* test/sram_model.sv */
// Behavioural model of the RX and TX packet SRAMs behind the register bank.
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  input wire logic aclk,
  input wire logic [15:0] rx_rd_addr,
  output logic [31:0] rx_rd_data,
  input wire sram_port_pkg::tx_sram_wr_t tx_wr
);
  import sram_port_pkg::*;
  int tx_count = 0;
  logic [15:0] tx_addr = 16'h0000;
  logic [31:0] tx_data = 32'h0;
  // Every address yields a distinct word, so a stale or skipped pointer shows in the data.
  assign rx_rd_data = {rx_rd_addr ^ 16'hA5A5, rx_rd_addr};
  always @(posedge aclk) begin
    if (tx_wr.en) begin
      tx_count <= tx_count + 1;
      tx_addr <= tx_wr.addr;
      tx_data <= tx_wr.data;
    end
  end
endmodule // sram_model
`default_nettype wire
